// *** common/modbus_switch_pkg.sv ***
// shared constants, types and register map of the remote switch and packing block
// assumes one 100 MHz core clock and a frame handler that presents one register at a time
package modbus_switch_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int BYTE_W = 8;
    localparam int OBJ_BYTES = 32;
    localparam int STATUS_W = 32;

    // ------------------------------------------------------------
    // register numbers and bus addresses
    // ------------------------------------------------------------
    localparam logic [15:0] NUM_TO_ADDR = 16'h0001;
    localparam logic [15:0] SWITCH_ONE_NUM = 16'hb501;
    localparam logic [15:0] SWITCH_TWO_NUM = 16'hb502;
    localparam logic [15:0] SWITCH_ONE_ADDR = SWITCH_ONE_NUM - NUM_TO_ADDR;
    localparam logic [15:0] SWITCH_TWO_ADDR = SWITCH_TWO_NUM - NUM_TO_ADDR;
    localparam logic [15:0] SWITCH_RESET = 16'h0000;

    // ------------------------------------------------------------
    // function codes that may write the switch registers
    // ------------------------------------------------------------
    localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;

    // ------------------------------------------------------------
    // packing figures
    // ------------------------------------------------------------
    localparam logic [5:0] REGS_ONE = 6'h01;
    localparam logic [5:0] REGS_TWO = 6'h02;
    localparam logic [5:0] REGS_SHORT = 6'h08;
    localparam logic [5:0] REGS_LONG = 6'h10;
    localparam logic [5:0] DATE_TIME_BYTES = 6'h03;
    localparam logic [5:0] SHORT_BYTES = 6'h10;
    localparam logic [5:0] LONG_BYTES = 6'h20;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // object data types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SIGNED_BYTE_TYPE = 4'h0,
        UNSIGNED_BYTE_TYPE = 4'h1,
        BIT_BYTE_TYPE = 4'h2,
        CHAR_TYPE = 4'h3,
        LIST_TYPE = 4'h4,
        WORD16_TYPE = 4'h5,
        WORD32_TYPE = 4'h6,
        SHORT_TEXT_TYPE = 4'h7,
        LONG_TEXT_TYPE = 4'h8,
        DATE_TYPE = 4'h9,
        TIME_TYPE = 4'ha,
        DOMAIN_TYPE = 4'hb,
        STRING_TYPE = 4'hc
    } obj_type_t;

    // one register access from the frame handler
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wrData;
    } reg_req_t;

    // answer to one register access
    typedef struct packed {
        logic done;
        logic refused;
        logic [15:0] rdData;
    } reg_rsp_t;

    // one word request of a packed object
    typedef struct packed {
        logic req;
        obj_type_t objType;
        logic [5:0] objLen;
        logic [4:0] wordIdx;
        logic [OBJ_BYTES-1:0][7:0] objBytes;
    } obj_req_t;

    // one packed word
    typedef struct packed {
        logic valid;
        logic inRange;
        logic [5:0] regCount;
        logic [15:0] word;
    } obj_rsp_t;

    // whole state of the top module
    typedef struct packed {
        logic [15:0] switchOne;
        logic [15:0] switchTwo;
        logic changed;
        reg_rsp_t regRsp;
        obj_rsp_t objRsp;
    } core_state_t;

endpackage

// *** core/modbus_switch_and_type_packing.sv ***
// top of the remote switch registers and typed object packing
// assumes a frame handler on core_clk presents one register access at a time
//
// Contract
// - two switch registers, writable anytime by function 6 or 16.
// - every switch bit is one of 32 binary statuses for logical outputs.
// - switch writes need no password unless a general write password applies.
// - two read-back values mirror the switches at family-dependent read addresses.
// - first word bit 0 is status 1; second word bit 0 is status 17.
// - signed byte sits low, high byte is its sign extension.
// - unsigned, bit, char and list bytes sit low with zero high.
// - 16-bit objects: bits 15-8 high byte, bits 7-0 low byte.
// - 32-bit objects use two registers, upper half first.
// - short text: eight registers, fifteen chars, terminated, high byte first.
// - long text: sixteen registers, thirty-one chars, same packing.
// - date: day high, month low; then year high, zero low; all bcd.
// - time: hour high, minute low; then second high, zero low; bcd.
// - byte array two per register, even high; odd length ends zero low.
// - general string length comes from its definition, 8-bit language coding.
`timescale 1ns/100ps
`default_nettype none
module modbus_switch_and_type_packing #(
    // read-back addresses vary by family; neutral defaults
    parameter logic [15:0] BACKREAD_ONE_ADDR = 16'h0100,
    parameter logic [15:0] BACKREAD_TWO_ADDR = 16'h0101
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register access from the frame handler
    input wire modbus_switch_pkg::reg_req_t regReq,
    output modbus_switch_pkg::reg_rsp_t regRsp,
    // general write password state
    input wire logic writePasswordOn,
    input wire logic writePasswordOk,
    // binary statuses for the logical binary outputs
    output logic [31:0] remoteSwitchStatusBits,
    output logic remoteSwitchChanged,
    // typed object packing
    input wire modbus_switch_pkg::obj_req_t objReq,
    output modbus_switch_pkg::obj_rsp_t objRsp
);
    // --------------------------------------------------------
    // address decoding helpers
    // --------------------------------------------------------

    // write target; the master already subtracted one from the number
    function automatic logic isSwitchAddr(input logic [15:0] addr);
        return (addr == modbus_switch_pkg::SWITCH_ONE_ADDR) ||
               (addr == modbus_switch_pkg::SWITCH_TWO_ADDR);
    endfunction

    function automatic logic isBackreadAddr(input logic [15:0] addr);
        return (addr == BACKREAD_ONE_ADDR) || (addr == BACKREAD_TWO_ADDR);
    endfunction

    function automatic logic isWriteFunc(input logic [7:0] func);
        return (func == modbus_switch_pkg::FUNC_WRITE_SINGLE) ||
               (func == modbus_switch_pkg::FUNC_WRITE_MULTI);
    endfunction

    // --------------------------------------------------------
    // reset release
    // --------------------------------------------------------
    logic syncReset_n;

    reset_release u_reset_release (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .syncReset_n(syncReset_n)
    );

    // --------------------------------------------------------
    // object packer
    // --------------------------------------------------------
    logic [15:0] packWord;
    logic [5:0] packCount;
    logic packInRange;

    type_word_packer u_type_word_packer (
        .objReq(objReq),
        .word(packWord),
        .regCount(packCount),
        .inRange(packInRange)
    );

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    modbus_switch_pkg::core_state_t state_ff;
    modbus_switch_pkg::core_state_t nxt_state;

    logic writeAllowed;
    logic wrHitOne;
    logic wrHitTwo;
    logic [15:0] rdWord;
    logic rdHit;

    // password gate: open unless a general write password is on and not given
    assign writeAllowed = !writePasswordOn || writePasswordOk;

    // write targets
    assign wrHitOne = (regReq.addr == modbus_switch_pkg::SWITCH_ONE_ADDR);
    assign wrHitTwo = (regReq.addr == modbus_switch_pkg::SWITCH_TWO_ADDR);

    // read-back mux; write addresses are write only and refuse reads
    always_comb begin
        rdWord = 16'h0000;
        rdHit = isBackreadAddr(regReq.addr);
        if (regReq.addr == BACKREAD_ONE_ADDR) begin
            rdWord = state_ff.switchOne;
        end else if (regReq.addr == BACKREAD_TWO_ADDR) begin
            rdWord = state_ff.switchTwo;
        end
    end

    // --------------------------------------------------------
    // next state
    // --------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        // answer and change flags are one-cycle pulses
        nxt_state.regRsp.done = 1'b0;
        nxt_state.regRsp.refused = 1'b0;
        nxt_state.changed = 1'b0;
        nxt_state.objRsp.valid = 1'b0;

        if (regReq.wrEn) begin
            nxt_state.regRsp.done = 1'b1;
            nxt_state.regRsp.rdData = 16'h0000;
            // any time, by either write function, if the password gate is open
            if (isSwitchAddr(regReq.addr) && isWriteFunc(regReq.func) &&
                writeAllowed) begin
                if (wrHitOne) begin
                    nxt_state.switchOne = regReq.wrData;
                    nxt_state.changed = (regReq.wrData != state_ff.switchOne);
                end
                if (wrHitTwo) begin
                    nxt_state.switchTwo = regReq.wrData;
                    nxt_state.changed = (regReq.wrData != state_ff.switchTwo);
                end
            end else begin
                // unmapped, wrong function or password closed: value kept
                nxt_state.regRsp.refused = 1'b1;
            end
        end else if (regReq.rdEn) begin
            nxt_state.regRsp.done = 1'b1;
            nxt_state.regRsp.rdData = rdWord;
            nxt_state.regRsp.refused = !rdHit;
        end
        // with no accepted write the switch words simply hold

        // packed word of a typed object, registered for a clean output
        if (objReq.req) begin
            nxt_state.objRsp.valid = 1'b1;
            nxt_state.objRsp.inRange = packInRange;
            nxt_state.objRsp.regCount = packCount;
            // words past the object's length read as zero
            nxt_state.objRsp.word = packInRange ? packWord : 16'h0000;
        end
    end

    // --------------------------------------------------------
    // state register
    // --------------------------------------------------------
    always_ff @(posedge core_clk or negedge syncReset_n) begin
        if (!syncReset_n) begin
            state_ff <= '0;
            state_ff.switchOne <= modbus_switch_pkg::SWITCH_RESET;
            state_ff.switchTwo <= modbus_switch_pkg::SWITCH_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // --------------------------------------------------------
    // outputs, all straight from the state register
    // --------------------------------------------------------
    // status 1 is bit 0 of word one, status 17 is bit 0 of word two
    assign remoteSwitchStatusBits = {state_ff.switchTwo, state_ff.switchOne};
    assign remoteSwitchChanged = state_ff.changed;
    assign regRsp = state_ff.regRsp;
    assign objRsp = state_ff.objRsp;
endmodule
`default_nettype wire

// *** core/reset_release.sv ***
// reset release: asserts at once, releases after two core clock edges
// assumes reset_n is asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module reset_release (
    // clock and raw reset
    input wire logic core_clk,
    input wire logic reset_n,
    // released copy
    output logic syncReset_n
);
    logic [1:0] stage_ff;

    // --------------------------------------------------------
    // two stage release keeps release off the clock edge hazard
    // --------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_ff <= 2'b00;
        end else begin
            stage_ff <= {stage_ff[0], 1'b1};
        end
    end

    assign syncReset_n = stage_ff[1];
endmodule
`default_nettype wire

// *** core/type_word_packer.sv ***
// combinational packer: one 16-bit register word of a typed object
// assumes numeric values sit little endian in objBytes, streams in index order
`timescale 1ns/100ps
`default_nettype none
module type_word_packer (
    // object in
    input wire modbus_switch_pkg::obj_req_t objReq,
    // word out
    output logic [15:0] word,
    output logic [5:0] regCount,
    output logic inRange
);
    // byte of a stream, zero past its length or on the terminator slot
    function automatic logic [7:0] streamByte(input modbus_switch_pkg::obj_req_t r,
                                              input logic [5:0] idx,
                                              input logic [5:0] nBytes,
                                              input logic forceTerm);
        logic [7:0] b;
        b = r.objBytes[idx[4:0]];
        if (idx >= nBytes) begin
            b = modbus_switch_pkg::BYTE_ZERO;
        end else if (forceTerm && (idx == nBytes - 6'h01)) begin
            b = modbus_switch_pkg::BYTE_ZERO;
        end
        return b;
    endfunction

    logic [5:0] hiIdx;
    logic [5:0] loIdx;
    logic [5:0] nBytes;
    logic isStream;
    logic isText;

    // --------------------------------------------------------
    // per type layout
    // --------------------------------------------------------
    always_comb begin
        hiIdx = {objReq.wordIdx, 1'b0};
        loIdx = {objReq.wordIdx, 1'b1};
        nBytes = objReq.objLen;
        isStream = 1'b0;
        isText = 1'b0;
        word = 16'h0000;
        regCount = modbus_switch_pkg::REGS_ONE;
        case (objReq.objType)
            modbus_switch_pkg::SIGNED_BYTE_TYPE: begin
                word = {{8{objReq.objBytes[0][7]}}, objReq.objBytes[0]};
            end
            modbus_switch_pkg::UNSIGNED_BYTE_TYPE, modbus_switch_pkg::BIT_BYTE_TYPE,
            modbus_switch_pkg::CHAR_TYPE, modbus_switch_pkg::LIST_TYPE: begin
                word = {modbus_switch_pkg::BYTE_ZERO, objReq.objBytes[0]};
            end
            modbus_switch_pkg::WORD16_TYPE: begin
                word = {objReq.objBytes[1], objReq.objBytes[0]};
            end
            modbus_switch_pkg::WORD32_TYPE: begin
                regCount = modbus_switch_pkg::REGS_TWO;
                // most significant half goes first
                word = (objReq.wordIdx == 5'h00) ?
                       {objReq.objBytes[3], objReq.objBytes[2]} :
                       {objReq.objBytes[1], objReq.objBytes[0]};
            end
            modbus_switch_pkg::SHORT_TEXT_TYPE: begin
                regCount = modbus_switch_pkg::REGS_SHORT;
                nBytes = modbus_switch_pkg::SHORT_BYTES;
                isStream = 1'b1;
                isText = 1'b1;
            end
            modbus_switch_pkg::LONG_TEXT_TYPE: begin
                regCount = modbus_switch_pkg::REGS_LONG;
                nBytes = modbus_switch_pkg::LONG_BYTES;
                isStream = 1'b1;
                isText = 1'b1;
            end
            modbus_switch_pkg::DATE_TYPE, modbus_switch_pkg::TIME_TYPE: begin
                // day/month/year or hour/minute/second as three bcd bytes
                regCount = modbus_switch_pkg::REGS_TWO;
                nBytes = modbus_switch_pkg::DATE_TIME_BYTES;
                isStream = 1'b1;
            end
            modbus_switch_pkg::DOMAIN_TYPE: begin
                regCount = 6'((objReq.objLen + 6'h01) >> 1);
                isStream = 1'b1;
            end
            modbus_switch_pkg::STRING_TYPE: begin
                // length given as a register count by the object's definition
                regCount = objReq.objLen;
                nBytes = 6'(objReq.objLen << 1);
                isStream = 1'b1;
            end
            default: begin
                word = 16'h0000;
            end
        endcase
        if (isStream) begin
            word = {streamByte(objReq, hiIdx, nBytes, isText),
                    streamByte(objReq, loIdx, nBytes, isText)};
        end
        inRange = ({1'b0, objReq.wordIdx} < regCount);
    end
endmodule
`default_nettype wire

// *** verif/bus_master_model.sv ***
// partner model: bus master presenting one register access per cycle
// assumes the bench hands over register numbers, not bus addresses
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
    // clock
    input wire logic core_clk,
    // order from the bench, addr holds the register number
    input wire modbus_switch_pkg::reg_req_t cmd,
    // access towards the block
    output modbus_switch_pkg::reg_req_t regReq
);
    // ------------------------------------------------------------
    // launch just after each edge
    // ------------------------------------------------------------
    initial regReq = '0;
    // idle lines flip so a stale value never looks valid
    always @(posedge core_clk) begin
        if (cmd.wrEn || cmd.rdEn) begin
            regReq <= '{cmd.wrEn, cmd.rdEn, cmd.func, cmd.addr - 16'h0001, cmd.wrData};
        end else begin
            regReq <= '{1'b0, 1'b0, ~regReq.func, ~regReq.addr, ~regReq.wrData};
        end
    end
endmodule
`default_nettype wire

// *** verif/modbus_switch_and_type_packing_tb.sv ***
// self-checking bench of the remote switch registers and object packing
// assumes the bus master model in front of the register port
`timescale 1ns/100ps
`default_nettype none
module modbus_switch_and_type_packing_tb;
    // ------------------------------------------------------------
    // bench state, instances and tasks
    // ------------------------------------------------------------
    localparam logic [15:0] BR1 = 16'h0200;
    localparam logic [15:0] BR2 = 16'h0201;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic pwOn = 1'b0;
    logic pwOk = 1'b0;
    modbus_switch_pkg::reg_req_t cmd = '0;
    modbus_switch_pkg::reg_req_t regReq;
    modbus_switch_pkg::reg_rsp_t regRsp;
    modbus_switch_pkg::obj_req_t objReq = '0;
    modbus_switch_pkg::obj_rsp_t objRsp;
    logic [31:0] statusBits;
    logic swChanged;
    logic [15:0] sw1 = 16'h0000;
    logic [15:0] sw2 = 16'h0000;
    logic [49:0] regQ [$];
    logic [22:0] objQ [$];
    int errors = 0;
    int samples_checked = 0;
    always #5 core_clk = ~core_clk;
    bus_master_model bus_master_model_inst (.core_clk(core_clk), .cmd(cmd), .regReq(regReq));
    modbus_switch_and_type_packing #(
        .BACKREAD_ONE_ADDR(BR1),
        .BACKREAD_TWO_ADDR(BR2)
    ) modbus_switch_and_type_packing_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .regReq(regReq),
        .regRsp(regRsp),
        .writePasswordOn(pwOn),
        .writePasswordOk(pwOk),
        .remoteSwitchStatusBits(statusBits),
        .remoteSwitchChanged(swChanged),
        .objReq(objReq),
        .objRsp(objRsp)
    );
    task automatic finish_test();
        if (regQ.size() != 0 || objQ.size() != 0) errors++;
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp_reg(logic [49:0] exp, logic [49:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic cmp_obj(logic [22:0] exp, logic [22:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // expected word of one object register, type codes as in the package
    function automatic logic [22:0] pack_exp(modbus_switch_pkg::obj_req_t r);
        logic [5:0] n;
        logic [7:0] hi;
        logic [7:0] lo;
        int k;
        k = 2 * r.wordIdx % 32;
        hi = r.objBytes[k];
        lo = r.objBytes[k + 1];
        n = 6'h01;
        case (r.objType)
            4'h0: hi = {8{r.objBytes[0][7]}};
            4'h1, 4'h2, 4'h3, 4'h4: hi = 8'h00;
            4'h5: {hi, lo} = {r.objBytes[1], r.objBytes[0]};
            4'h6: {n, hi, lo} = {6'h02, r.objBytes[3 - k % 4], r.objBytes[2 - k % 4]};
            4'h7: {n, lo} = {6'h08, k == 14 ? 8'h00 : lo};
            4'h8: {n, lo} = {6'h10, k == 30 ? 8'h00 : lo};
            4'h9, 4'ha: {n, lo} = {6'h02, k != 0 ? 8'h00 : lo};
            4'hb: {n, lo} = {6'((r.objLen + 6'h01) >> 1), k + 1 >= r.objLen ? 8'h00 : lo};
            default: n = r.objLen;
        endcase
        if (r.objType <= 4'h5 && k == 0) lo = r.objBytes[0];
        if (r.wordIdx >= n) return {1'b0, n, 16'h0000};
        return {1'b1, n, hi, lo};
    endfunction
    // one access per call; shadow words note what a correct block answers
    task automatic reg_op(logic wr, logic [7:0] fn, logic [15:0] num, logic [15:0] d);
        logic ok;
        logic chg;
        chg = 1'b0;
        ok = num == BR1 + 16'h0001 || num == BR2 + 16'h0001;
        if (wr) begin
            ok = (fn == 8'h06 || fn == 8'h10) && !(pwOn && !pwOk);
            ok = ok && (num == 16'hb501 || num == 16'hb502);
            // change pulse only when an accepted write moves the word
            chg = ok && d != (num == 16'hb501 ? sw1 : sw2);
            if (ok) {sw2, sw1} = num == 16'hb501 ? {sw2, d} : {d, sw1};
        end
        @(posedge core_clk);
        #1;
        cmd = '{wr, !wr, fn, num, d};
        regQ.push_back({chg, !ok, wr || !ok ? 16'h0000 : num == BR1 + 16'h0001 ? sw1 : sw2,
            sw2, sw1});
    endtask
    task automatic idle(int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
            cmd.wrEn = 1'b0;
            cmd.rdEn = 1'b0;
            objReq.req = 1'b0;
        end
    endtask
    // answers looked at mid-cycle, oldest note first
    always @(negedge core_clk) begin
        if (regRsp.done === 1'b1) cmp_reg(regQ.pop_front(), {swChanged, regRsp[16:0], statusBits});
        if (objRsp.valid === 1'b1) cmp_obj(objQ.pop_front(), objRsp[22:0]);
    end
    // hang guard, far beyond the roughly 540 cycles the run needs
    initial begin
        #50000;
        errors++;
        finish_test();
    end
    initial begin
        logic [15:0] nums [4];
        logic [255:0] b;
        logic [5:0] len;
        nums = '{16'hb501, 16'hb502, BR1 + 16'h0001, BR2 + 16'h0001};
        void'($urandom(32'h07fa4dfe));
        repeat (16) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        idle(4);
        reg_op(1'b1, 8'h06, 16'hb501, 16'h000f);
        reg_op(1'b1, 8'h10, 16'hb502, 16'hf000);
        reg_op(1'b0, 8'h03, BR1 + 16'h0001, 16'h0000);
        reg_op(1'b0, 8'h03, BR2 + 16'h0001, 16'h0000);
        reg_op(1'b1, 8'h03, 16'hb501, 16'h1234);
        reg_op(1'b1, 8'h06, 16'hb500, 16'h4321);
        reg_op(1'b1, 8'h06, 16'hb503, 16'h4321);
        reg_op(1'b0, 8'h03, 16'hb501, 16'h0000);
        idle(2);
        pwOn = 1'b1;
        reg_op(1'b1, 8'h06, 16'hb501, 16'haaaa);
        idle(2);
        pwOk = 1'b1;
        reg_op(1'b1, 8'h10, 16'hb502, 16'h5555);
        idle(2);
        pwOn = 1'b0;
        repeat (60) reg_op($urandom_range(0, 1), $urandom_range(0, 1) ? 8'h06 : 8'h10,
            nums[$urandom_range(0, 3)], 16'($urandom));
        // drop the last access so it is not repeated under the object run
        idle(2);
        for (int t = 0; t < 26; t++) begin
            for (int j = 0; j < 8; j++) b[j * 32 +: 32] = $urandom;
            len = t / 2 == 11 ? 6'($urandom_range(1, 32)) : 6'($urandom_range(1, 16));
            for (int i = 0; i < 17; i++) begin
                @(posedge core_clk);
                #1;
                objReq = '{1'b1, modbus_switch_pkg::obj_type_t'(t / 2), len, 5'(i), b};
                objQ.push_back(pack_exp(objReq));
            end
        end
        idle(4);
        finish_test();
    end
endmodule
`default_nettype wire

// *** verif/switch_pack_props.sv ***
// checker of the remote switch register port, bound onto the top module
// assumes one core clock and the raw active low reset of the top module
`timescale 1ns/100ps
`default_nettype none
module switch_pack_props #(
    parameter logic [15:0] BACKREAD_ONE_ADDR = 16'h0100
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register port
    input wire modbus_switch_pkg::reg_req_t regReq,
    input wire modbus_switch_pkg::reg_rsp_t regRsp,
    // password and statuses
    input wire logic writePasswordOn,
    input wire logic writePasswordOk,
    input wire logic [31:0] remoteSwitchStatusBits
);
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic funcOk;
    logic passOk;
    logic anyReq;
    // helper terms keep the sampled functions on plain signals
    assign funcOk = regReq.func == 8'h06 || regReq.func == 8'h10;
    assign passOk = !writePasswordOn || writePasswordOk;
    assign anyReq = regReq.wrEn || regReq.rdEn;
    sequence take_one_s;
        regReq.wrEn && funcOk && passOk && regReq.addr == 16'hb500;
    endsequence
    sequence take_two_s;
        regReq.wrEn && funcOk && passOk && regReq.addr == 16'hb501;
    endsequence
    sequence done_ok_s;
        regRsp.done && !regRsp.refused;
    endsequence
    req_answered_a: assert property (anyReq |=> regRsp.done)
        else $error("request without answer");
    no_stray_done_a: assert property (regRsp.done |-> $past(anyReq))
        else $error("answer without request");
    word_one_a: assert property (take_one_s |=> done_ok_s
        ##0 remoteSwitchStatusBits[15:0] == $past(regReq.wrData)) else $error("word one lost");
    word_two_a: assert property (take_two_s |=> done_ok_s
        ##0 remoteSwitchStatusBits[31:16] == $past(regReq.wrData)) else $error("word two lost");
    bad_func_a: assert property (regReq.wrEn && !funcOk
        |=> regRsp.refused && $stable(remoteSwitchStatusBits)) else $error("bad function taken");
    pass_block_a: assert property (regReq.wrEn && !passOk
        |=> regRsp.refused && $stable(remoteSwitchStatusBits)) else $error("password ignored");
    status_hold_a: assert property (!regReq.wrEn |=> $stable(remoteSwitchStatusBits))
        else $error("status moved without write");
    read_back_a: assert property (regReq.rdEn && !regReq.wrEn
        && regReq.addr == BACKREAD_ONE_ADDR |=> done_ok_s
        ##0 regRsp.rdData == remoteSwitchStatusBits[15:0]) else $error("read back wrong");
endmodule
bind modbus_switch_and_type_packing switch_pack_props #(
    .BACKREAD_ONE_ADDR(BACKREAD_ONE_ADDR)
) switch_pack_props_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .regReq(regReq),
    .regRsp(regRsp),
    .writePasswordOn(writePasswordOn),
    .writePasswordOk(writePasswordOk),
    .remoteSwitchStatusBits(remoteSwitchStatusBits)
);
`default_nettype wire
